// >>> etx_line_map.svh
// register map, field positions and timing constants of the e3 transmit line encoder
//------------------------------------------------------------
// Summary of operation
// - hdb3 replaces four zeros by 000V or B00V
// - B keeps alternation, V breaks it
// - odd pulse count between consecutive V pulses
// - otherwise hdb3 encodes exactly like ami
// - control bit 4: 0 hdb3, 1 ami
// - code select ignored in single-rail mode
// - code select shared with receive decoder
// - edge select 0: rails change on rising
// - edge select 1: rails change on falling
// - line clock driven alongside both rails
// - control bit 3: 0 dual, 1 single
// - single rail: nrz positive, frame on negative
// - ami marks alternate, zeros give no pulse
// - positive rail positive, negative rail negative
//------------------------------------------------------------
`ifndef ETX_LINE_MAP_SVH
`define ETX_LINE_MAP_SVH

// register indices, byte address is four times the index
`define ETX_IDX_IO_CTRL 6'h01
`define ETX_IDX_STATUS 6'h02
`define ETX_ADDR_LSB 2

// line_io_control layout and defaults
`define ETX_IO_CTRL_RESET 8'ha0
`define ETX_IO_CTRL_WMASK 8'hbf
`define ETX_BIT_TX_LOSS_DIS 7
`define ETX_BIT_LOSS 6
`define ETX_BIT_RX_LOSS_DIS 5
`define ETX_BIT_CODE 4
`define ETX_BIT_MODE 3
`define ETX_BIT_OUT_EDGE 2
`define ETX_BIT_IN_EDGE 1
`define ETX_BIT_REFRAME 0

// coding and timing
`define ETX_ZERO_RUN 4
`define ETX_CLK_PERIOD_NS 5
`define ETX_LOSS_TIME_NS 800
`define ETX_LOSS_CYC (`ETX_LOSS_TIME_NS / `ETX_CLK_PERIOD_NS)

`endif

// >>> etx_pkg.sv
// types shared by the e3 transmit line encoder files
package etx_pkg;

  // meaning of one bit slot in the coding pipeline
  typedef enum logic [1:0] {TAG_NONE, TAG_MARK, TAG_B, TAG_V} etx_tag_t;

  // one bit slot: data, frame marker and its pulse kind
  typedef struct packed {
    logic data;
    logic frame;
    etx_tag_t tag;
  } etx_slot_t;

  // settings handed to the receive decoder of the channel
  typedef struct packed {
    logic loss_disable;
    logic code_select;
    logic single_rail;
    logic in_edge_select;
    logic reframe;
  } etx_rx_cfg_t;

endpackage

// >>> etx_hdb3_core.sv
// ami and hdb3 symbol coder with a four slot look-ahead pipeline
`timescale 1ns/1ps
`include "etx_line_map.svh"

module etx_hdb3_core
  import etx_pkg::*;
#(
  parameter int DEPTH = `ETX_ZERO_RUN // slots of look-ahead
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic bit_en_in,
  input wire logic data_in,
  input wire logic frame_in,
  input wire logic code_ami_in,
  output logic sym_data_out,
  output logic sym_frame_out,
  output logic sym_pos_out,
  output logic sym_neg_out
);

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  etx_slot_t [DEPTH-1:0] pipe_reg, pipe_next; // slot 0 newest
  logic pol_reg, pol_next; // 1: last pulse was positive
  logic par_reg, par_next; // odd pulses since last V
  logic data_reg, data_next;
  logic frame_reg, frame_next;
  logic pos_reg, pos_next;
  logic neg_reg, neg_next;
  logic win_zero; // window free for substitution
  etx_slot_t cur; // slot leaving the pipeline

  assign cur = pipe_reg[DEPTH-1];

  // next state: emit oldest slot, shift, tag new zero runs
  always_comb begin
    pipe_next = pipe_reg;
    pol_next = pol_reg;
    par_next = par_reg;
    data_next = data_reg;
    frame_next = frame_reg;
    pos_next = pos_reg;
    neg_next = neg_reg;
    win_zero = 1'b0;
    if (bit_en_in) begin
      data_next = cur.data;
      frame_next = cur.frame;
      case (cur.tag)
        TAG_MARK, TAG_B: begin
          // alternate from the last pulse
          pos_next = !pol_reg;
          neg_next = pol_reg;
          pol_next = !pol_reg;
          par_next = !par_reg;
        end
        TAG_V: begin
          // repeat last polarity on purpose
          pos_next = pol_reg;
          neg_next = !pol_reg;
          par_next = 1'b0;
        end
        default: begin
          pos_next = 1'b0; // zeros give no pulse
          neg_next = 1'b0;
        end
      endcase
      for (int i = DEPTH - 1; i > 0; i--) begin
        pipe_next[i] = pipe_reg[i-1];
      end
      pipe_next[0].data = data_in;
      pipe_next[0].frame = frame_in;
      pipe_next[0].tag = data_in ? TAG_MARK : TAG_NONE;
      if (!code_ami_in && !data_in) begin
        // three older zeros still untouched make a run of four
        win_zero = 1'b1;
        for (int i = 0; i < DEPTH - 1; i++) begin
          if (pipe_reg[i].tag != TAG_NONE) begin
            win_zero = 1'b0;
          end
        end
        if (win_zero) begin
          pipe_next[0].tag = TAG_V;
          if (!par_next) begin
            pipe_next[DEPTH-1].tag = TAG_B; // even count: B00V
          end
        end
      end
    end
  end

  // registers only
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      pipe_reg <= '0;
      pol_reg <= 1'b0;
      par_reg <= 1'b0;
      data_reg <= 1'b0;
      frame_reg <= 1'b0;
      pos_reg <= 1'b0;
      neg_reg <= 1'b0;
    end else begin
      pipe_reg <= pipe_next;
      pol_reg <= pol_next;
      par_reg <= par_next;
      data_reg <= data_next;
      frame_reg <= frame_next;
      pos_reg <= pos_next;
      neg_reg <= neg_next;
    end
  end

  assign sym_data_out = data_reg;
  assign sym_frame_out = frame_reg;
  assign sym_pos_out = pos_reg;
  assign sym_neg_out = neg_reg;

  //------------------------------------------------------------
  // assertions and their helpers
  //------------------------------------------------------------
  logic [2:0] zrun_reg; // zero symbols in a row
  logic [2:0] warm_reg; // slots emitted since reset
  logic seen_v_reg; // a V has already gone out

  // helper counters, only the checks read them
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      zrun_reg <= 3'h0;
      warm_reg <= 3'h0;
      seen_v_reg <= 1'b0;
    end else if (bit_en_in) begin
      if (warm_reg != 3'h7) begin
        warm_reg <= warm_reg + 3'h1;
      end
      if (cur.tag == TAG_V) begin
        seen_v_reg <= 1'b1;
      end
      if (cur.tag != TAG_NONE || code_ami_in) begin
        zrun_reg <= 3'h0;
      end else if (zrun_reg != 3'h7) begin
        zrun_reg <= zrun_reg + 3'h1;
      end
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  a_zero_run: assert property (warm_reg > 3'h4 |-> zrun_reg < 3'h4)
    else $error("four zero symbols left the hdb3 coder");
  a_b_polarity: assert property (bit_en_in && cur.tag == TAG_B |=> sym_pos_out == !$past(pol_reg)
    && sym_neg_out == $past(pol_reg))
    else $error("B pulse broke alternation");
  a_v_polarity: assert property (bit_en_in && cur.tag == TAG_V |=> sym_pos_out == $past(pol_reg))
    else $error("V pulse did not violate alternation");
  a_v_odd: assert property (bit_en_in && cur.tag == TAG_V && seen_v_reg |-> par_reg)
    else $error("even pulse count between two V pulses");
  a_ami_plain: assert property (code_ami_in && bit_en_in |=> pipe_reg[0].tag != TAG_V)
    else $error("substitution made in ami coding");
  a_mark_alt: assert property (bit_en_in && cur.tag == TAG_MARK |=> (sym_pos_out ^ sym_neg_out)
    && sym_pos_out == !$past(pol_reg))
    else $error("mark did not alternate");

endmodule // etx_hdb3_core

// >>> etx_line_encoder.sv
// e3 transmit line encoder: line clock recovery, rail coding and apb registers
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "etx_line_map.svh"

module etx_line_encoder
  import etx_pkg::*;
#(
  parameter int ADDR_W = 8, // apb byte address width
  parameter int LOSS_CYC = `ETX_LOSS_CYC // cycles without a line clock edge
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic line_clk_in,
  input wire logic tx_data_in,
  input wire logic tx_frame_start_in,
  output logic bit_take_out,
  output logic out_rail_positive_out,
  output logic out_rail_negative_out,
  output logic out_line_clock_out,
  output etx_rx_cfg_t rx_cfg_out
);

  localparam int LW = $clog2(LOSS_CYC + 1); // loss counter width

  //------------------------------------------------------------
  // line clock synchroniser and edge finder
  //------------------------------------------------------------
  logic [2:0] sync_reg, sync_next; // [0] first stage, [2] delayed copy
  logic rise_edge; // line clock rose
  logic fall_edge; // line clock fell
  logic act_edge; // edge chosen for rail updates

  // shift the pin in; only stage two onward is looked at
  always_comb begin
    sync_next = {sync_reg[1:0], line_clk_in};
  end

  // synchroniser registers
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      sync_reg <= 3'h0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign rise_edge = sync_reg[1] && !sync_reg[2];
  assign fall_edge = !sync_reg[1] && sync_reg[2];

  //------------------------------------------------------------
  // control register and loss of line clock
  //------------------------------------------------------------
  logic [7:0] line_io_control_reg, line_io_control_next;
  logic [LW-1:0] loss_cnt_reg, loss_cnt_next; // cycles since last edge
  logic loss_flag_reg, loss_flag_next; // line clock has stopped
  etx_rx_cfg_t rx_cfg_reg, rx_cfg_next; // copy for the receive decoder
  logic acc_done; // apb access ends this edge
  logic hit_ctrl; // address is the control register
  logic hit_stat; // address is the status register
  logic [ADDR_W-`ETX_ADDR_LSB-1:0] idx; // register index

  // edge select steers which edge moves the rails
  assign act_edge = line_io_control_reg[`ETX_BIT_OUT_EDGE] ? fall_edge : rise_edge;

  assign idx = paddr_in[ADDR_W-1:`ETX_ADDR_LSB];

  // decode: if/else chain, lane bits must be zero
  always_comb begin
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    if (paddr_in[`ETX_ADDR_LSB-1:0] != '0) begin
      hit_ctrl = 1'b0; // unaligned: unmapped
    end else if (idx == (ADDR_W-`ETX_ADDR_LSB)'(`ETX_IDX_IO_CTRL)) begin
      hit_ctrl = 1'b1;
    end else if (idx == (ADDR_W-`ETX_ADDR_LSB)'(`ETX_IDX_STATUS)) begin
      hit_stat = 1'b1;
    end
  end

  // next control, loss and shared settings
  always_comb begin
    line_io_control_next = line_io_control_reg;
    if (acc_done && pwrite_in && hit_ctrl) begin
      // loss flag bit is read-only, keep it clear in storage
      line_io_control_next = pwdata_in[7:0] & `ETX_IO_CTRL_WMASK;
    end
    // counter saturates, an edge restarts it
    if (rise_edge || fall_edge) begin
      loss_cnt_next = '0;
    end else if (loss_cnt_reg != LW'(LOSS_CYC)) begin
      loss_cnt_next = loss_cnt_reg + LW'(1);
    end else begin
      loss_cnt_next = loss_cnt_reg;
    end
    loss_flag_next = (loss_cnt_reg == LW'(LOSS_CYC))
      && !line_io_control_reg[`ETX_BIT_TX_LOSS_DIS];
    // same setting drives the receive side decoding
    rx_cfg_next.code_select = line_io_control_next[`ETX_BIT_CODE];
    rx_cfg_next.single_rail = line_io_control_next[`ETX_BIT_MODE];
    rx_cfg_next.in_edge_select = line_io_control_next[`ETX_BIT_IN_EDGE];
    rx_cfg_next.loss_disable = line_io_control_next[`ETX_BIT_RX_LOSS_DIS];
    rx_cfg_next.reframe = line_io_control_next[`ETX_BIT_REFRAME];
  end

  // control registers
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      line_io_control_reg <= `ETX_IO_CTRL_RESET;
      loss_cnt_reg <= '0;
      loss_flag_reg <= 1'b0;
      rx_cfg_reg <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    end else begin
      line_io_control_reg <= line_io_control_next;
      loss_cnt_reg <= loss_cnt_next;
      loss_flag_reg <= loss_flag_next;
      rx_cfg_reg <= rx_cfg_next;
    end
  end

  //------------------------------------------------------------
  // apb slave: one wait state, registered answer
  //------------------------------------------------------------
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;

  assign acc_done = psel_in && penable_in && pready_reg;

  // answer the access phase one cycle after it opens
  always_comb begin
    pready_next = psel_in && penable_in && !pready_reg;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (psel_in && penable_in && !pready_reg) begin
      prdata_next = 32'h0;
      if (hit_ctrl) begin
        prdata_next[7:0] = line_io_control_reg;
        prdata_next[`ETX_BIT_LOSS] = loss_flag_reg;
      end else if (hit_stat) begin
        // live rail and clock levels for bring-up
        prdata_next[2:0] = {out_line_clock_out, out_rail_negative_out,
          out_rail_positive_out};
      end else begin
        pslverr_next = 1'b1; // unmapped address
      end
    end
  end

  // bus answer registers
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  assign pready_out = pready_reg;
  assign pslverr_out = pslverr_reg;
  assign prdata_out = prdata_reg;
  assign rx_cfg_out = rx_cfg_reg;

  //------------------------------------------------------------
  // symbol coder
  //------------------------------------------------------------
  logic enc_data; // nrz bit leaving the pipeline
  logic enc_frame; // frame marker of that bit
  logic enc_pos; // coded positive pulse
  logic enc_neg; // coded negative pulse

  // pipeline also carries single-rail data so mode changes stay aligned
  etx_hdb3_core #(
    .DEPTH(`ETX_ZERO_RUN)
  ) u_coder (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .bit_en_in(act_edge),
    .data_in(tx_data_in),
    .frame_in(tx_frame_start_in),
    .code_ami_in(line_io_control_reg[`ETX_BIT_CODE]),
    .sym_data_out(enc_data),
    .sym_frame_out(enc_frame),
    .sym_pos_out(enc_pos),
    .sym_neg_out(enc_neg)
  );

  //------------------------------------------------------------
  // rails and line clock out
  //------------------------------------------------------------
  logic pos_reg, pos_next;
  logic neg_reg, neg_next;
  logic lclk_reg, lclk_next;
  logic take_reg, take_next;

  // rails move only on the selected edge, together with the clock copy
  always_comb begin
    pos_next = pos_reg;
    neg_next = neg_reg;
    take_next = act_edge; // tells the framer its bit was taken
    lclk_next = sync_reg[1];
    if (act_edge) begin
      if (line_io_control_reg[`ETX_BIT_MODE]) begin
        // single rail: code select has no say here
        pos_next = enc_data;
        neg_next = enc_frame;
      end else begin
        pos_next = enc_pos;
        neg_next = enc_neg;
      end
    end
  end

  // output registers, every top output leaves a flop
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      pos_reg <= 1'b0;
      neg_reg <= 1'b0;
      lclk_reg <= 1'b0;
      take_reg <= 1'b0;
    end else begin
      pos_reg <= pos_next;
      neg_reg <= neg_next;
      lclk_reg <= lclk_next;
      take_reg <= take_next;
    end
  end

  assign out_rail_positive_out = pos_reg;
  assign out_rail_negative_out = neg_reg;
  assign out_line_clock_out = lclk_reg;
  assign bit_take_out = take_reg;

  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  a_rail_rise: assert property (($changed(pos_reg) || $changed(neg_reg))
    && !$past(line_io_control_reg[`ETX_BIT_OUT_EDGE])
    |-> lclk_reg && !$past(lclk_reg))
    else $error("rails moved away from a rising line clock edge");
  a_rail_fall: assert property (($changed(pos_reg) || $changed(neg_reg))
    && $past(line_io_control_reg[`ETX_BIT_OUT_EDGE])
    |-> !lclk_reg && $past(lclk_reg))
    else $error("rails moved away from a falling line clock edge");
  a_clock_follow: assert property ($rose(sync_reg[1]) |=> lclk_reg)
    else $error("line clock out did not follow");
  a_dual_excl: assert property (act_edge && !line_io_control_reg[`ETX_BIT_MODE]
    |=> !(pos_reg && neg_reg))
    else $error("both rails high in dual rail mode");
  a_single_rail: assert property (act_edge && line_io_control_reg[`ETX_BIT_MODE]
    |=> pos_reg == $past(enc_data) && neg_reg == $past(enc_frame))
    else $error("single rail output wrong");
  a_code_share: assert property (acc_done && pwrite_in && hit_ctrl
    |=> rx_cfg_out.code_select == $past(pwdata_in[`ETX_BIT_CODE]))
    else $error("receive side code select not updated");
  a_apb_ready: assert property (psel_in && penable_in && !pready_reg |=> pready_reg ##1 !pready_reg)
    else $error("apb answer not one wait state");

endmodule // etx_line_encoder

// >>> etx_liu_model.sv
// line interface unit model: samples both rails with the encoder's line clock
`timescale 1ns/1ps

module etx_liu_model (
  input wire logic line_clock_in, // line clock from the encoder
  input wire logic rail_pos_in, // positive rail
  input wire logic rail_neg_in, // negative rail
  input wire logic edge_select_in, // 1: encoder updates rails on falling
  output logic pos_seen_out, // last sampled positive rail
  output logic neg_seen_out // last sampled negative rail
);
  //----------------------------------------
  // sampling
  //----------------------------------------
  // samples on the edge away from the update, mid bit, where the rails
  // have settled; a rail that moves mid period shows up as a wrong sample
  initial begin
    pos_seen_out = 1'b0;
    neg_seen_out = 1'b0;
  end
  always @(line_clock_in) begin
    if (line_clock_in === edge_select_in) begin
      pos_seen_out = rail_pos_in;
      neg_seen_out = rail_neg_in;
    end
  end
endmodule // etx_liu_model

// >>> etx_line_encoder_tb.sv
// self-checking bench of the e3 transmit line encoder
`timescale 1ns/1ps

module etx_line_encoder_tb;
  import etx_pkg::*;
  //----------------------------------------
  // signals
  //----------------------------------------
  logic mclk, rstn, psel, penable, pwrite, lclk, lclk_en, txd, txf, esel;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, take, rp, rn, oclk, sp, sn, e;
  etx_rx_cfg_t cfg;
  integer n_mismatch, checked, t;
  logic ep [0:69]; // expected positive rail per bit
  logic en [0:69]; // expected negative rail per bit
  logic bits [0:69]; // framer bits
  logic frs [0:69]; // frame start markers
  logic [7:0] cfgs [0:4] = '{8'ha0, 8'hb0, 8'ha4, 8'ha8, 8'hb8}; // stream setups

  etx_line_encoder #(.ADDR_W(8), .LOSS_CYC(64)) u_etx_line_encoder (
    .mclk_in(mclk), .rstn_in(rstn), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .line_clk_in(lclk), .tx_data_in(txd), .tx_frame_start_in(txf),
    .bit_take_out(take), .out_rail_positive_out(rp), .out_rail_negative_out(rn),
    .out_line_clock_out(oclk), .rx_cfg_out(cfg));
  etx_liu_model u_etx_liu_model (
    .line_clock_in(oclk), .rail_pos_in(rp), .rail_neg_in(rn),
    .edge_select_in(esel), .pos_seen_out(sp), .neg_seen_out(sn));

  //----------------------------------------
  // clocks
  //----------------------------------------
  always #2.5 mclk = ~mclk;
  // line clock, odd phase offset; stands still between streams
  initial begin
    lclk = 1'b0;
    #3.7;
    forever begin
      #80;
      if (lclk_en) lclk = ~lclk;
    end
  end

  //----------------------------------------
  // helpers
  //----------------------------------------
  task chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, x, s);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // a bounded wait ran out
  task hang;
    n_mismatch++;
    $display("CHECK FAILED handshake expected answer seen none");
    finish_test;
  endtask
  task do_reset(input int c);
    rstn <= 1'b0;
    repeat (c) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) hang;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  //----------------------------------------
  // one coded stream with its reference model
  //----------------------------------------
  task run(input logic [7:0] ctrl);
    integer i, k, pol, np, zc;
    do_reset(3);
    apb(1'b1, 8'h04, {24'h0, ctrl});
    esel = ctrl[2];
    pol = -1;
    np = 0;
    zc = 0;
    for (i = 0; i < 70; i++) begin
      bits[i] = (i == 0) || ($urandom % 4 == 0);
      frs[i] = (i % 24 == 0);
      ep[i] = ctrl[3] ? bits[i] : 1'b0;
      en[i] = ctrl[3] ? frs[i] : 1'b0;
      if (!ctrl[3] && bits[i]) begin // mark alternates
        pol = -pol;
        np++;
        zc = 0;
        ep[i] = pol > 0;
        en[i] = pol < 0;
      end else if (!ctrl[3]) begin
        zc++;
        if (!ctrl[4] && zc == 4) begin // four zeros replaced
          if (np % 2 == 0) begin // even count needs a B
            pol = -pol;
            ep[i-3] = pol > 0;
            en[i-3] = pol < 0;
          end
          ep[i] = pol > 0; // violation repeats polarity
          en[i] = pol < 0;
          np = 0;
          zc = 0;
        end
      end
    end
    txd <= bits[0];
    txf <= frs[0];
    lclk_en = 1'b1;
    for (i = 0; i < 66; i++) begin
      k = 0;
      do begin
        @(posedge mclk);
        k++;
      end while (take !== 1'b1 && k < 100);
      if (take !== 1'b1) hang;
      if (i >= 2) chk("line clock at update", 32'(!ctrl[2]), 32'(oclk));
      if (i >= 7) chk("positive rail", 32'(ep[i-6]), 32'(sp));
      if (i >= 7) chk("negative rail", 32'(en[i-6]), 32'(sn));
      txd <= bits[i+1];
      txf <= frs[i+1];
    end
    // stop the line clock low so a later reset sees no edge
    k = 0;
    while (lclk !== 1'b0 && k < 100) begin
      @(posedge mclk);
      k++;
    end
    lclk_en = 1'b0;
    txd <= 1'b0;
    $display("test stream %0h done", ctrl);
  endtask

  //----------------------------------------
  // main sequence
  //----------------------------------------
  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lclk_en = 1'b0;
    txd = 1'b0;
    txf = 1'b0;
    esel = 1'b0;
    n_mismatch = 0;
    checked = 0;
    void'($urandom(32'h51cf));
    do_reset(20);
    // register defaults, read-only flag, shared setting, unmapped place
    apb(1'b0, 8'h04, 32'h0);
    chk("control reset", 32'ha0, r);
    apb(1'b1, 8'h04, 32'hff);
    apb(1'b0, 8'h04, 32'h0);
    chk("control write", 32'hbf, r);
    // unaligned write is refused and must leave the settings alone
    apb(1'b1, 8'h05, 32'h0);
    chk("unaligned error", 32'h1, 32'(e));
    chk("shared code select", 32'h1, 32'(cfg.code_select));
    chk("shared mode", 32'h1, 32'(cfg.single_rail));
    chk("shared settings", 32'h1f, 32'(cfg));
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped error", 32'h1, 32'(e));
    // no line clock yet: rails and clock copy still low
    apb(1'b0, 8'h08, 32'h0);
    chk("status idle", 32'h0, r);
    chk("status error", 32'h0, 32'(e));
    $display("test registers done");
    for (t = 0; t < 5; t++) run(cfgs[t]);
    // loss flag rises with the line clock stopped and detection on
    apb(1'b1, 8'h04, 32'h20);
    repeat (100) @(posedge mclk);
    apb(1'b0, 8'h04, 32'h0);
    chk("loss flag", 32'h60, r);
    $display("test loss flag done");
    finish_test;
  end
endmodule // etx_line_encoder_tb
